/* File: verilog/sice_defines.svh */
/*
 * Constants for the interrupt code encoder: code values, event bit
 * positions and reset values.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef SICE_DEFINES_SVH
`define SICE_DEFINES_SVH

// interrupt codes presented to the host
`define SICE_C_SCSI_RST     8'h01
`define SICE_C_SCSI_PAR     8'h24
`define SICE_C_MPU_PAR      8'h22
`define SICE_C_DMA_PAR      8'h21
`define SICE_C_SCSI_MPU_PAR 8'h26
`define SICE_C_SCSI_DMA_PAR 8'h25
`define SICE_C_OFFSET       8'h29
`define SICE_C_PERIOD       8'h2A
`define SICE_C_OFS_PER      8'h2B
`define SICE_C_TIMEOUT      8'h2C
`define SICE_C_BUS_FREE     8'h31
`define SICE_C_PHASE        8'h32
`define SICE_C_INIT_PH      8'h54
`define SICE_C_INIT_MSG     8'h55
`define SICE_C_INIT_STS     8'h56
`define SICE_C_INIT_MSG_NR  8'h5D
`define SICE_C_INIT_STS_NR  8'h5E
`define SICE_C_ATN_STOP     8'h42
`define SICE_C_ATN_MSG      8'h43
`define SICE_C_ATN_MSG_NR   8'h47

// event bit positions in the pending vector
`define SICE_NEV            11
`define SICE_EV_RST         0
`define SICE_EV_SCSI_PAR    1
`define SICE_EV_MPU_PAR     2
`define SICE_EV_DMA_PAR     3
`define SICE_EV_OFFSET      4
`define SICE_EV_PERIOD      5
`define SICE_EV_TIMEOUT     6
`define SICE_EV_BUS_FREE    7
`define SICE_EV_PHASE       8
`define SICE_EV_INIT_PH     9
`define SICE_EV_ATN         10

// reset values
`define SICE_CODE_RST       8'h00
`define SICE_PEND_RST       11'h000

`endif

/* File: verilog/sice_pkg.sv */
/*
 * Types for the interrupt code encoder.
 * Assumes sice_defines.svh supplies the numeric constants.
 */
package sice_pkg;

	// detection pulses from the protocol controller, one cycle each
	typedef struct packed {
		logic atn_stop;
		logic init_phase;
		logic phase_err;
		logic bus_free;
		logic reqack_tmo;
		logic period_err;
		logic offset_err;
		logic dma_par;
		logic mpu_par;
		logic scsi_par;
	} sice_event_t;

	// levels describing the controller's current situation
	typedef struct packed {
		logic prog_xfer;
		logic dma_xfer;
		logic sync_mode;
		logic auto_rx;
		logic req_msg;
		logic req_status;
		logic rx_buf_full;
		logic datain_req;
		logic nexused;
	} sice_ctx_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_HELD    = 2'b01,
		ST_SYNC_IN = 2'b10
	} sice_state_t;

endpackage

/* File: verilog/sice_code_reg.sv */
/*
 * Holding register for one interrupt code until the host reads it.
 * Assumes load is only asserted while the register is empty.
 */
`timescale 1ns/10ps
`include "sice_defines.svh"

module sice_code_reg
	import sice_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset,
	input  wire logic       i_load,
	input  wire logic [7:0] i_code,
	input  wire logic       i_read,
	output logic      [7:0] o_code,
	output logic            o_valid
);

	// code storage, cleared on reset only
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_code <= `SICE_CODE_RST;
		end else if (i_load) begin
			o_code <= i_code;
		end
	end

	// valid flag: load sets, host read clears, load wins
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_valid <= 1'b0;
		end else if (i_load) begin
			o_valid <= 1'b1;
		end else if (i_read) begin
			o_valid <= 1'b0;
		end
	end

endmodule

/* File: verilog/sice_encoder.sv */
/*
 * Interrupt code encoder: turns condition detections of the protocol
 * controller into one 8-bit interrupt code held for the host.
 * Assumes event pulses and context levels come from logic on i_clk_sys;
 * the SCSI reset and REQ lines come from pins and are synchronised here.
 */
`timescale 1ns/10ps
`include "sice_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module sice_encoder
	import sice_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_scsi_rst_pin,
	input  wire logic        i_scsi_req_pin,
	input  wire sice_event_t i_events,
	input  wire sice_ctx_t   i_ctx,
	input  wire logic        i_code_read,
	output logic       [7:0] o_int_code,
	output logic             o_int_valid,
	output logic             o_int_req,
	output logic             o_rx_strobe,
	output logic             o_ack_inhibit,
	output logic             o_data_reg_flush,
	output logic             o_clr_mod_cnt
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic        rst_meta, rst_sync, rst_prev, rst_edge;
	logic        req_meta, req_sync, req_prev, req_edge;

	// two flops on each bus line before any logic looks at it
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
			rst_prev <= 1'b0;
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_prev <= 1'b0;
		end else begin
			rst_meta <= i_scsi_rst_pin;
			rst_sync <= rst_meta;
			rst_prev <= rst_sync;
			req_meta <= i_scsi_req_pin;
			req_sync <= req_meta;
			req_prev <= req_sync;
		end
	end

	// edge detectors read only the second flop and later
	assign rst_edge = rst_sync & ~rst_prev;
	assign req_edge = req_sync & ~req_prev;

	////////////////////////////////////////////////////////////////////////
	// pending event flags

	logic [`SICE_NEV-1:0] ev_vec, pending, pend_now, consume;
	sice_state_t          state;
	logic                 load;

	assign ev_vec   = {i_events, rst_edge};
	assign pend_now = pending | ev_vec;
	assign load     = (state == ST_IDLE) && (|pend_now);

	// events waiting while a code is held stay sticky; a new event wins
	// over the consumption of one already pending so nothing is lost
	genvar gi;
	generate
		for (gi = 0; gi < `SICE_NEV; gi++) begin : g_pend
			always_ff @(posedge i_clk_sys or posedge i_reset) begin
				if (i_reset) begin
					pending[gi] <= 1'b0;
				end else if (ev_vec[gi]) begin
					pending[gi] <= ~(load & consume[gi] & ~pending[gi]);
				end else if (load && consume[gi]) begin
					pending[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// priority encoder: reset, transfer errors, phase transitions

	logic [7:0] next_code;
	logic       next_take, next_refuse, next_flush, next_sync_in;

	always_comb begin
		next_code    = `SICE_CODE_RST;
		consume      = '0;
		next_take    = 1'b0;
		next_refuse  = 1'b0;
		next_flush   = 1'b0;
		next_sync_in = 1'b0;
		if (pend_now[`SICE_EV_RST]) begin
			next_code = `SICE_C_SCSI_RST;
			consume[`SICE_EV_RST] = 1'b1;
		end else if (pend_now[`SICE_EV_SCSI_PAR] && pend_now[`SICE_EV_MPU_PAR]
			&& i_ctx.prog_xfer) begin
			next_code = `SICE_C_SCSI_MPU_PAR;
			consume[`SICE_EV_SCSI_PAR] = 1'b1;
			consume[`SICE_EV_MPU_PAR] = 1'b1;
		end else if (pend_now[`SICE_EV_SCSI_PAR] && pend_now[`SICE_EV_DMA_PAR]
			&& i_ctx.dma_xfer) begin
			next_code = `SICE_C_SCSI_DMA_PAR;
			consume[`SICE_EV_SCSI_PAR] = 1'b1;
			consume[`SICE_EV_DMA_PAR] = 1'b1;
		end else if (pend_now[`SICE_EV_SCSI_PAR]) begin
			next_code = `SICE_C_SCSI_PAR;
			consume[`SICE_EV_SCSI_PAR] = 1'b1;
		end else if (pend_now[`SICE_EV_MPU_PAR]) begin
			next_code = `SICE_C_MPU_PAR;
			consume[`SICE_EV_MPU_PAR] = 1'b1;
		end else if (pend_now[`SICE_EV_DMA_PAR]) begin
			next_code = `SICE_C_DMA_PAR;
			consume[`SICE_EV_DMA_PAR] = 1'b1;
		end else if (pend_now[`SICE_EV_OFFSET] && pend_now[`SICE_EV_PERIOD]) begin
			next_code = `SICE_C_OFS_PER;
			consume[`SICE_EV_OFFSET] = 1'b1;
			consume[`SICE_EV_PERIOD] = 1'b1;
		end else if (pend_now[`SICE_EV_OFFSET]) begin
			next_code = `SICE_C_OFFSET;
			consume[`SICE_EV_OFFSET] = 1'b1;
		end else if (pend_now[`SICE_EV_PERIOD]) begin
			next_code = `SICE_C_PERIOD;
			consume[`SICE_EV_PERIOD] = 1'b1;
		end else if (pend_now[`SICE_EV_TIMEOUT]) begin
			next_code = `SICE_C_TIMEOUT;
			consume[`SICE_EV_TIMEOUT] = 1'b1;
		end else if (pend_now[`SICE_EV_BUS_FREE]) begin
			next_code = `SICE_C_BUS_FREE;
			consume[`SICE_EV_BUS_FREE] = 1'b1;
		end else if (pend_now[`SICE_EV_PHASE]) begin
			next_code = `SICE_C_PHASE;
			consume[`SICE_EV_PHASE] = 1'b1;
		end else if (pend_now[`SICE_EV_INIT_PH]) begin
			consume[`SICE_EV_INIT_PH] = 1'b1;
			next_code = `SICE_C_INIT_PH;
			// message and status variants exist only in automatic receive mode; data-in after a phase error takes a byte without it
			if (i_ctx.auto_rx && i_ctx.req_msg) begin
				next_code   = i_ctx.rx_buf_full ? `SICE_C_INIT_MSG_NR
					: `SICE_C_INIT_MSG;
				next_take   = ~i_ctx.rx_buf_full;
				next_refuse = i_ctx.rx_buf_full;
			end else if (i_ctx.auto_rx && i_ctx.req_status) begin
				next_code   = i_ctx.rx_buf_full ? `SICE_C_INIT_STS_NR
					: `SICE_C_INIT_STS;
				next_take   = ~i_ctx.rx_buf_full;
				next_refuse = i_ctx.rx_buf_full;
			end else if (i_ctx.datain_req && i_ctx.nexused) begin
				// data-in after a phase error: one byte, or per REQ when sync
				next_take    = ~i_ctx.sync_mode;
				next_sync_in = i_ctx.sync_mode;
			end
		end else if (pend_now[`SICE_EV_ATN]) begin
			consume[`SICE_EV_ATN] = 1'b1;
			next_flush = 1'b1;
			if (!i_ctx.auto_rx) begin
				next_code = `SICE_C_ATN_STOP;
			end else begin
				next_code   = i_ctx.rx_buf_full ? `SICE_C_ATN_MSG_NR
					: `SICE_C_ATN_MSG;
				next_take   = ~i_ctx.rx_buf_full;
				next_refuse = i_ctx.rx_buf_full;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// holding register for the code

	sice_code_reg u_code_reg (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_load    (load),
		.i_code    (next_code),
		.i_read    (i_code_read),
		.o_code    (o_int_code),
		.o_valid   (o_int_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// hold state: one code at a time, freed by the host read

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (load) begin
						state <= next_sync_in ? ST_SYNC_IN : ST_HELD;
					end
				end
				ST_HELD, ST_SYNC_IN: begin
					if (i_code_read) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// side effects toward the transfer logic

	// interrupt request follows the held code
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_int_req <= 1'b0;
		end else if (load) begin
			o_int_req <= 1'b1;
		end else if (i_code_read) begin
			o_int_req <= 1'b0;
		end
	end

	// byte take strobe: once at load when a byte is taken, or once per REQ in sync data-in
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_rx_strobe <= 1'b0;
		end else begin
			o_rx_strobe <= (load & next_take)
				| ((state == ST_SYNC_IN) & req_edge);
		end
	end

	// ACK held off while bytes are gathered per REQ
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_ack_inhibit <= 1'b0;
		end else if (load) begin
			o_ack_inhibit <= next_sync_in;
		end else if (i_code_read) begin
			o_ack_inhibit <= 1'b0;
		end
	end

	// data register emptied on every stop code
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_data_reg_flush <= 1'b0;
		end else begin
			o_data_reg_flush <= load & next_flush;
		end
	end

	// refused byte clears the modified-byte counter
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_clr_mod_cnt <= 1'b0;
		end else begin
			o_clr_mod_cnt <= load & next_refuse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	logic idle;
	assign idle = (state == ST_IDLE);

	property p_rst_code;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now[`SICE_EV_RST]) |=> (o_int_valid && o_int_code == 8'h01);
	endproperty
	a_rst_code: assert property (p_rst_code) else $error("reset code wrong");

	property p_scsi_par;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h002) |=> (o_int_code == 8'h24);
	endproperty
	a_scsi_par: assert property (p_scsi_par) else $error("scsi parity code wrong");

	property p_mpu_scsi;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h006 && i_ctx.prog_xfer) |=> (o_int_code == 8'h26);
	endproperty
	a_mpu_scsi: assert property (p_mpu_scsi) else $error("combined parity wrong");

	property p_ofs_per;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h030) |=> (o_int_code == 8'h2B) ##1 !pending[4];
	endproperty
	a_ofs_per: assert property (p_ofs_per) else $error("combined sync code wrong");

	property p_init_ph;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h200 && !i_ctx.auto_rx)
			|=> (o_int_code == 8'h54 && !o_clr_mod_cnt);
	endproperty
	a_init_ph: assert property (p_init_ph) else $error("initial phase code wrong");

	property p_msg_refused;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h200 && i_ctx.auto_rx && i_ctx.req_msg && i_ctx.rx_buf_full)
			|=> (o_int_code == 8'h5D && o_clr_mod_cnt && !o_rx_strobe);
	endproperty
	a_msg_refused: assert property (p_msg_refused) else $error("refused msg wrong");

	property p_atn_msg;
		@(posedge i_clk_sys) disable iff (i_reset)
		(idle && pend_now == 11'h400 && i_ctx.auto_rx && !i_ctx.rx_buf_full)
			|=> (o_int_code == 8'h43 && o_rx_strobe && o_data_reg_flush) ##1 !o_rx_strobe;
	endproperty
	a_atn_msg: assert property (p_atn_msg) else $error("atn msg code wrong");

	property p_refuse_clear;
		@(posedge i_clk_sys) disable iff (i_reset)
		o_clr_mod_cnt |-> (o_int_code == 8'h5D || o_int_code == 8'h5E || o_int_code == 8'h47);
	endproperty
	a_refuse_clear: assert property (p_refuse_clear) else $error("stray counter clear");

	property p_hold;
		@(posedge i_clk_sys) disable iff (i_reset)
		(o_int_valid && !i_code_read) |=> (o_int_valid && $stable(o_int_code));
	endproperty
	a_hold: assert property (p_hold) else $error("code lost before read");

	property p_sync_no_ack;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state == ST_SYNC_IN) |-> (o_ack_inhibit && o_int_code == 8'h54);
	endproperty
	a_sync_no_ack: assert property (p_sync_no_ack) else $error("ack not held off");

	c_combined_dma: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		load && next_code == 8'h25);
	c_atn_refused: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		load && next_code == 8'h47);
	c_sync_in: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		(state == ST_SYNC_IN) && o_rx_strobe);
	c_queued: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		o_int_valid && i_code_read ##1 load);

endmodule

/* File: dv/sice_host_model.sv */
/*
 * Host processor model: answers an interrupt request by reading the
 * held code after a programmable number of cycles.
 * Assumes the encoder's clock and reset; the delay input comes from the bench.
 */
`timescale 1ns/10ps

module sice_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset,
	input  wire logic       i_int_req,
	input  wire logic [7:0] i_delay,
	output logic            o_code_read
);
	logic [7:0] wait_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// count while the request stands, then give one read pulse
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_code_read <= 1'b0;
			wait_cnt    <= 8'h00;
		end else begin
			o_code_read <= 1'b0;
			if (i_int_req && !o_code_read) begin
				if (wait_cnt >= i_delay) begin
					o_code_read <= 1'b1;
					wait_cnt    <= 8'h00;
				end else begin
					wait_cnt <= wait_cnt + 8'h01;
				end
			end else begin
				wait_cnt <= 8'h00;
			end
		end
	end
endmodule

/* File: dv/tb.sv */
/*
 * Self-checking bench for the interrupt code encoder: directed cases for
 * every code, synchronous data-in after a phase error, and random mixes.
 * Assumes the encoder and the host model; expectations come from pick().
 */
`timescale 1ns/10ps

module tb
	import sice_pkg::*;
;
	`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

	logic        i_clk_sys = 1'b0;
	logic        i_reset = 1'b1;
	logic        rst_pin = 1'b0;
	logic        req_pin = 1'b0;
	sice_event_t ev = '0;
	sice_ctx_t   ctx = '0;
	logic [7:0]  host_dly = 8'h00;
	logic        code_read;
	logic [7:0]  o_int_code;
	logic        o_int_valid, o_int_req, o_rx_strobe, o_ack_inhibit, o_data_reg_flush;
	logic        o_clr_mod_cnt;
	int          errors = 0;
	int          num_checks = 0;
	int          n, k;

	always #5 i_clk_sys = ~i_clk_sys;

	sice_encoder i_sice_encoder (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_scsi_rst_pin(rst_pin), .i_scsi_req_pin(req_pin), .i_events(ev), .i_ctx(ctx),
		.i_code_read(code_read), .o_int_code(o_int_code), .o_int_valid(o_int_valid),
		.o_int_req(o_int_req), .o_rx_strobe(o_rx_strobe), .o_ack_inhibit(o_ack_inhibit),
		.o_data_reg_flush(o_data_reg_flush), .o_clr_mod_cnt(o_clr_mod_cnt));

	sice_host_model i_sice_host_model (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_int_req(o_int_req), .i_delay(host_dly), .o_code_read(code_read));

	////////////////////////////////////////////////////////////////////////////////
	// expected next code, side pulses {strobe, ack hold, flush, clear} and bits used
	function automatic void pick(input logic [10:0] p, input sice_ctx_t c,
		output logic [7:0] code, output logic [3:0] side, output logic [10:0] used);
		sice_event_t e;
		logic        dn;
		e = sice_event_t'(p[9:0]);
		dn = c.datain_req && c.nexused;
		if (p[10]) begin
			code = 8'h01;
			used = 11'h400;
		end else if (e.scsi_par && e.mpu_par && c.prog_xfer) begin
			code = 8'h26;
			used = 11'h003;
		end else if (e.scsi_par && e.dma_par && c.dma_xfer) begin
			code = 8'h25;
			used = 11'h005;
		end else if (e.scsi_par) begin
			code = 8'h24;
			used = 11'h001;
		end else if (e.mpu_par) begin
			code = 8'h22;
			used = 11'h002;
		end else if (e.dma_par) begin
			code = 8'h21;
			used = 11'h004;
		end else if (e.offset_err && e.period_err) begin
			code = 8'h2B;
			used = 11'h018;
		end else if (e.offset_err) begin
			code = 8'h29;
			used = 11'h008;
		end else if (e.period_err) begin
			code = 8'h2A;
			used = 11'h010;
		end else if (e.reqack_tmo) begin
			code = 8'h2C;
			used = 11'h020;
		end else if (e.bus_free) begin
			code = 8'h31;
			used = 11'h040;
		end else if (e.phase_err) begin
			code = 8'h32;
			used = 11'h080;
		end else if (e.init_phase) begin
			used = 11'h100;
			if (c.auto_rx && c.req_msg) code = c.rx_buf_full ? 8'h5D : 8'h55;
			else if (c.auto_rx && c.req_status) code = c.rx_buf_full ? 8'h5E : 8'h56;
			else code = 8'h54;
		end else begin
			used = 11'h200;
			code = !c.auto_rx ? 8'h42 : (c.rx_buf_full ? 8'h47 : 8'h43);
		end
		side[3] = code == 8'h55 || code == 8'h56 || code == 8'h43 ||
			(code == 8'h54 && dn && !c.sync_mode);
		side[2] = code == 8'h54 && dn && c.sync_mode;
		side[1] = code == 8'h42 || code == 8'h43 || code == 8'h47;
		side[0] = code == 8'h5D || code == 8'h5E || code == 8'h47;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pulse a set of events, then follow every code until the host has read them all
	task automatic run_case(input logic [10:0] pend, input logic [8:0] cx);
		logic [7:0]  ec;
		logic [3:0]  es;
		logic [10:0] cm, p;
		logic        pv, hit;
		int          w;
		p = pend;
		pv = 1'b0;
		@(posedge i_clk_sys);
		ctx <= sice_ctx_t'(cx);
		host_dly <= 8'($urandom_range(0, 4));
		@(posedge i_clk_sys);
		ev <= sice_event_t'(pend[9:0]);
		rst_pin <= pend[10];
		@(posedge i_clk_sys);
		ev <= '0;
		rst_pin <= 1'b0;
		while (p != 11'h000) begin
			pick(p, sice_ctx_t'(cx), ec, es, cm);
			w = 0;
			do begin
				@(negedge i_clk_sys);
				w++;
				hit = o_int_valid === 1'b1 && pv === 1'b0;
				pv = o_int_valid;
			end while (!hit && w < 30);
			`CHK(hit, 1'b1)
			`CHK(o_int_code, ec)
			`CHK(o_int_req, 1'b1)
			`CHK({o_rx_strobe, o_ack_inhibit, o_data_reg_flush, o_clr_mod_cnt}, es)
			p = p & ~cm;
		end
		repeat (16) @(negedge i_clk_sys);
		`CHK(o_int_valid, 1'b0)
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#200_000;
		errors++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(14289));
		repeat (10) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		@(negedge i_clk_sys);
		`CHK({o_int_code, o_int_valid, o_int_req}, 10'h000)
		run_case(11'h400, 9'h000);
		run_case(11'h001, 9'h000);
		run_case(11'h002, 9'h000);
		run_case(11'h004, 9'h080);
		run_case(11'h003, 9'h100);
		run_case(11'h005, 9'h080);
		run_case(11'h008, 9'h040);
		run_case(11'h010, 9'h040);
		run_case(11'h018, 9'h040);
		run_case(11'h020, 9'h000);
		run_case(11'h040, 9'h100);
		run_case(11'h080, 9'h080);
		run_case(11'h100, 9'h010);
		run_case(11'h100, 9'h030);
		run_case(11'h100, 9'h028);
		run_case(11'h100, 9'h034);
		run_case(11'h100, 9'h02C);
		run_case(11'h200, 9'h004);
		run_case(11'h200, 9'h020);
		run_case(11'h200, 9'h024);
		run_case(11'h100, 9'h003);
		// synchronous data-in: one byte per REQ, ACK held off until the read
		@(posedge i_clk_sys);
		ctx <= sice_ctx_t'(9'h043);
		host_dly <= 8'h3C;
		@(posedge i_clk_sys);
		ev <= sice_event_t'(10'h100);
		@(posedge i_clk_sys);
		ev <= '0;
		@(negedge i_clk_sys);
		`CHK({o_int_code, o_ack_inhibit, o_rx_strobe}, 10'h152)
		n = 0;
		for (int i = 0; i < 24; i++) begin
			@(posedge i_clk_sys);
			req_pin <= (i == 2 || i == 10);
			@(negedge i_clk_sys);
			n += int'(o_rx_strobe === 1'b1);
		end
		`CHK(n, 2)
		k = 0;
		while (o_int_valid !== 1'b0 && k < 100) begin
			@(negedge i_clk_sys);
			k++;
		end
		`CHK(o_int_valid, 1'b0)
		@(negedge i_clk_sys);
		`CHK(o_ack_inhibit, 1'b0)
		// reset in mid-run drops the held code and the one waiting behind it
		@(posedge i_clk_sys);
		ev <= sice_event_t'(10'h201);
		@(posedge i_clk_sys);
		ev <= '0;
		@(negedge i_clk_sys);
		`CHK({o_int_valid, o_int_code}, 9'h124)
		@(posedge i_clk_sys);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		@(negedge i_clk_sys);
		`CHK({o_int_code, o_int_valid, o_int_req}, 10'h000)
		repeat (20) @(negedge i_clk_sys);
		`CHK({o_int_valid, o_data_reg_flush, o_ack_inhibit}, 3'h0)
		// random mixes of events under random conditions
		for (int i = 0; i < 40; i++) begin
			logic [8:0] rc;
			rc = 9'($urandom_range(0, 511));
			if (rc[4])
				rc[3] = 1'b0;
			run_case({1'b0, 10'($urandom_range(1, 1023))}, rc);
		end
		final_report();
	end
endmodule
